// ### hdl/hthc_pkg.sv
package hthc_pkg;
    // Register offsets on the serial control port
    localparam logic [7:0] ADDR_HYBRID_TAP_EIGHT_COEFF = 8'h34;
    localparam logic [7:0] ADDR_RSVD_FIRST = 8'h35;
    localparam logic [7:0] ADDR_RSVD_LAST = 8'h3A;
    localparam logic [7:0] ADDR_CTRL = 8'h3B;
    // Control register field positions
    localparam int BIT_QUENCH_HIGH = 6;
    localparam int BIT_QUENCH_LOW = 4;
    localparam int BIT_RX_GAIN = 2;
    localparam int BIT_GUARD_EN = 1;
    // Serial frame: control byte, address byte, data byte
    localparam int BIT_CMD_READ = 5;
    localparam logic [4:0] CNT_CMD_LAST = 5'h07;
    localparam logic [4:0] CNT_ADDR_LAST = 5'h0F;
    localparam logic [4:0] CNT_DATA_LAST = 5'h17;
    localparam logic [4:0] CNT_FRAME_END = 5'h18;
    // Reset values
    localparam logic [7:0] RST_HYBRID_TAP_EIGHT_COEFF = 8'h00;
    localparam logic [3:0] RST_CTRL = 4'h0;
    localparam logic [7:0] RD_RESERVED = 8'h00;
    // On-hook release times
    localparam int MCLK_MHZ = 200;
    localparam int T_FAST_US = 500;
    localparam int T_MID_US = 3000;
    localparam int T_SLOW_US = 26000;
    // Fast time is strictly below its figure, so one cycle short
    localparam int FAST_CYC = T_FAST_US * MCLK_MHZ - 1;
    localparam int MID_CYC = T_MID_US * MCLK_MHZ;
    localparam int SLOW_CYC = T_SLOW_US * MCLK_MHZ;
    localparam int CNT_W = 23;

    typedef enum logic [2:0] {
        HK_ONHOOK = 3'b001,
        HK_OFFHOOK = 3'b010,
        HK_RELEASE = 3'b100
    } hthc_hook_t;

    typedef struct packed {
        logic [2:0] cs_s;
        logic [2:0] sclk_s;
        logic [2:0] sdi_s;
        logic cs_f;
        logic sclk_f;
        logic sdi_f;
        logic sclk_p;
        logic [4:0] bit_cnt;
        logic [7:0] shift;
        logic rd;
        logic [7:0] addr;
        logic [7:0] tx;
        logic sdo;
        logic [7:0] coeff;
        logic [3:0] ctrl;
        hthc_hook_t hk;
        logic [CNT_W-1:0] cnt;
        logic guard;
    } hthc_state_t;
endpackage : hthc_pkg

// ### hdl/hthc_regs.sv
`timescale 1ns/100ps
module hthc_regs #(
    parameter int P_FAST_CYC = hthc_pkg::FAST_CYC,
    parameter int P_MID_CYC = hthc_pkg::MID_CYC,
    parameter int P_SLOW_CYC = hthc_pkg::SLOW_CYC
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic spi_cs_n,
    input wire logic spi_sclk,
    input wire logic spi_sdi,
    output logic spi_sdo_o,
    output logic spi_sdo_oe,
    input wire logic offhook_control,
    input wire logic onhook_speed_sel_a,
    input wire logic onhook_speed_sel_b,
    input wire logic guard_companion_bit,
    output logic [7:0] hybrid_tap_eight_coeff,
    output logic hybrid_tap_eight_active,
    output logic quench_sel_high,
    output logic quench_sel_low,
    output logic rx_gain_step,
    output logic guarded_clear_enable,
    output logic loop_current_on,
    output logic guarded_clear_draw
);
    hthc_pkg::hthc_state_t q;
    hthc_pkg::hthc_state_t d;
    logic sclk_rise;
    logic sclk_fall;
    logic [7:0] byte_in;
    logic wr_done;
    logic [hthc_pkg::CNT_W-1:0] rel_cnt;

    function automatic logic [7:0] read_mux(input logic [7:0] a, input hthc_pkg::hthc_state_t s);
        logic [7:0] v;
        v = hthc_pkg::RD_RESERVED;
        if (a == hthc_pkg::ADDR_HYBRID_TAP_EIGHT_COEFF) begin
            v = s.coeff;
        end else if (a == hthc_pkg::ADDR_CTRL) begin
            // Reserved positions always read zero
            v[hthc_pkg::BIT_QUENCH_HIGH] = s.ctrl[3];
            v[hthc_pkg::BIT_QUENCH_LOW] = s.ctrl[2];
            v[hthc_pkg::BIT_RX_GAIN] = s.ctrl[1];
            v[hthc_pkg::BIT_GUARD_EN] = s.ctrl[0];
        end
        return v;
    endfunction : read_mux

    always_comb begin
        // Release time from quench and speed selects; illegal mixes fall back to fast
        if (onhook_speed_sel_a && q.ctrl[3] && q.ctrl[2]) begin
            rel_cnt = hthc_pkg::CNT_W'(P_SLOW_CYC - 1);
        end else if (!onhook_speed_sel_a && onhook_speed_sel_b && !q.ctrl[3] && !q.ctrl[2]) begin
            rel_cnt = hthc_pkg::CNT_W'(P_MID_CYC - 1);
        end else begin
            rel_cnt = hthc_pkg::CNT_W'(P_FAST_CYC - 1);
        end
    end

    always_comb begin
        d = q;
        wr_done = 1'b0;
        sclk_rise = q.sclk_f && !q.sclk_p;
        sclk_fall = !q.sclk_f && q.sclk_p;
        byte_in = {q.shift[6:0], q.sdi_f};
        // Three-stage synchronisers; a level counts once stages two and three agree
        d.cs_s = {q.cs_s[1:0], spi_cs_n};
        d.sclk_s = {q.sclk_s[1:0], spi_sclk};
        d.sdi_s = {q.sdi_s[1:0], spi_sdi};
        if (q.cs_s[1] == q.cs_s[2]) begin
            d.cs_f = q.cs_s[2];
        end
        if (q.sclk_s[1] == q.sclk_s[2]) begin
            d.sclk_f = q.sclk_s[2];
        end
        if (q.sdi_s[1] == q.sdi_s[2]) begin
            d.sdi_f = q.sdi_s[2];
        end
        d.sclk_p = q.sclk_f;
        // Serial frame
        if (q.cs_f) begin
            d.bit_cnt = 5'h00;
            d.rd = 1'b0;
            d.sdo = 1'b0;
        end else if (sclk_rise && q.bit_cnt != hthc_pkg::CNT_FRAME_END) begin
            d.shift = byte_in;
            d.bit_cnt = q.bit_cnt + 5'h01;
            if (q.bit_cnt == hthc_pkg::CNT_CMD_LAST) begin
                d.rd = byte_in[hthc_pkg::BIT_CMD_READ];
            end else if (q.bit_cnt == hthc_pkg::CNT_ADDR_LAST) begin
                d.addr = byte_in;
                d.tx = read_mux(byte_in, q);
            end else if (q.bit_cnt == hthc_pkg::CNT_DATA_LAST) begin
                wr_done = !q.rd;
            end
        end else if (sclk_fall && q.rd && q.bit_cnt > hthc_pkg::CNT_ADDR_LAST) begin
            d.sdo = q.tx[7];
            d.tx = {q.tx[6:0], 1'b0};
        end
        // Writes to reserved or unmapped numbers are dropped
        if (wr_done) begin
            if (q.addr == hthc_pkg::ADDR_HYBRID_TAP_EIGHT_COEFF) begin
                d.coeff = byte_in;
            end else if (q.addr == hthc_pkg::ADDR_CTRL) begin
                // Only defined bits are stored, so reserved ones cannot stick
                d.ctrl = {byte_in[hthc_pkg::BIT_QUENCH_HIGH], byte_in[hthc_pkg::BIT_QUENCH_LOW],
                    byte_in[hthc_pkg::BIT_RX_GAIN], byte_in[hthc_pkg::BIT_GUARD_EN]};
            end
        end
        // Hook release sequence
        unique case (q.hk)
            hthc_pkg::HK_ONHOOK: begin
                if (offhook_control) begin
                    d.hk = hthc_pkg::HK_OFFHOOK;
                end
            end
            hthc_pkg::HK_OFFHOOK: begin
                if (!offhook_control) begin
                    d.hk = hthc_pkg::HK_RELEASE;
                    d.cnt = rel_cnt;
                end
            end
            hthc_pkg::HK_RELEASE: begin
                if (offhook_control) begin
                    d.hk = hthc_pkg::HK_OFFHOOK;
                end else if (q.cnt == '0) begin
                    d.hk = hthc_pkg::HK_ONHOOK;
                end else begin
                    d.cnt = q.cnt - hthc_pkg::CNT_W'(1);
                end
            end
            default: begin
                d.hk = hthc_pkg::HK_ONHOOK;
            end
        endcase
        d.guard = (d.hk == hthc_pkg::HK_ONHOOK) && q.ctrl[0] && guard_companion_bit;
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            q <= '0;
            q.cs_s <= 3'h7;
            q.cs_f <= 1'b1;
            q.coeff <= hthc_pkg::RST_HYBRID_TAP_EIGHT_COEFF;
            q.ctrl <= hthc_pkg::RST_CTRL;
            q.hk <= hthc_pkg::HK_ONHOOK;
        end else begin
            q <= d;
        end
    end

    assign spi_sdo_o = q.sdo;
    assign spi_sdo_oe = !q.cs_f;
    assign hybrid_tap_eight_coeff = q.coeff;
    assign hybrid_tap_eight_active = |q.coeff;
    assign quench_sel_high = q.ctrl[3];
    assign quench_sel_low = q.ctrl[2];
    assign rx_gain_step = q.ctrl[1];
    assign guarded_clear_enable = q.ctrl[0];
    assign loop_current_on = (q.hk != hthc_pkg::HK_ONHOOK);
    assign guarded_clear_draw = q.guard;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    sequence s_release_begin;
        q.hk == hthc_pkg::HK_OFFHOOK && !offhook_control;
    endsequence
    sequence s_write_to(logic [7:0] a);
        wr_done && q.addr == a;
    endsequence

    a_tap_zero_idle: assert property (s_write_to(hthc_pkg::ADDR_HYBRID_TAP_EIGHT_COEFF)
        ##0 (byte_in == 8'h00) |=> !hybrid_tap_eight_active)
        else $error("zeroed tap still reported active");
    a_coeff_write: assert property (s_write_to(hthc_pkg::ADDR_HYBRID_TAP_EIGHT_COEFF) |=>
        hybrid_tap_eight_coeff == $past(byte_in))
        else $error("coefficient write not stored");
    a_rsvd_ignored: assert property (wr_done && q.addr != hthc_pkg::ADDR_HYBRID_TAP_EIGHT_COEFF
        && q.addr != hthc_pkg::ADDR_CTRL |=> $stable(q.coeff) && $stable(q.ctrl))
        else $error("reserved or unmapped write changed a register");
    a_ctrl_rsvd_zero: assert property (sclk_rise && !q.cs_f && q.bit_cnt == hthc_pkg::CNT_ADDR_LAST
        && byte_in == hthc_pkg::ADDR_CTRL |=> q.tx[7] == 1'b0 && q.tx[5] == 1'b0
        && q.tx[3] == 1'b0 && q.tx[0] == 1'b0)
        else $error("control readback shows reserved bits");
    a_gain_write: assert property (s_write_to(hthc_pkg::ADDR_CTRL) |=>
        rx_gain_step == $past(byte_in[hthc_pkg::BIT_RX_GAIN]))
        else $error("gain bit not updated by write");
    a_release_start: assert property (s_release_begin |=>
        q.hk == hthc_pkg::HK_RELEASE && loop_current_on)
        else $error("release did not start on off-hook clear");
    a_slow_select: assert property (s_release_begin ##0 (onhook_speed_sel_a && q.ctrl == 4'hC)
        |=> q.cnt == hthc_pkg::CNT_W'(P_SLOW_CYC - 1))
        else $error("slow release time not loaded");
    a_mid_select: assert property (s_release_begin ##0 (!onhook_speed_sel_a && onhook_speed_sel_b
        && q.ctrl[3:2] == 2'b00) |=> q.cnt == hthc_pkg::CNT_W'(P_MID_CYC - 1))
        else $error("mid release time not loaded");
    a_fast_select: assert property (s_release_begin ##0 (!onhook_speed_sel_a
        && !onhook_speed_sel_b && q.ctrl[3:2] == 2'b00)
        |=> q.cnt == hthc_pkg::CNT_W'(P_FAST_CYC - 1))
        else $error("fast release time not loaded");
    a_release_end: assert property (q.hk == hthc_pkg::HK_RELEASE && !offhook_control
        && q.cnt == '0 |=> !loop_current_on)
        else $error("loop current not dropped at end of release");
    a_guard_draw: assert property (guarded_clear_draw |->
        !loop_current_on && $past(q.ctrl[0]) && $past(guard_companion_bit))
        else $error("guard current drawn without its conditions");
    a_guard_onhook: assert property (q.hk == hthc_pkg::HK_ONHOOK && !offhook_control
        && q.ctrl[0] && guard_companion_bit |=> guarded_clear_draw)
        else $error("guard current missing while on-hook");
endmodule : hthc_regs

// ### bench/hthc_regs_tb.sv
`timescale 1ns/100ps
module hthc_regs_tb;
    logic mclk, nrst, spi_cs_n, spi_sclk, spi_sdi, spi_sdo_o, spi_sdo_oe;
    logic offhook_control, onhook_speed_sel_a, onhook_speed_sel_b, guard_companion_bit;
    logic [7:0] hybrid_tap_eight_coeff;
    logic hybrid_tap_eight_active, quench_sel_high, quench_sel_low, rx_gain_step;
    logic guarded_clear_enable, loop_current_on, guarded_clear_draw;
    int n_errors = 0;
    int checks_done = 0;
    logic [7:0] rd;
    int t_fast, t_mid, t_slow;

    // Short release counts keep the run brief
    hthc_regs #(.P_FAST_CYC(5), .P_MID_CYC(10), .P_SLOW_CYC(20)) uut (
        .mclk(mclk), .nrst(nrst), .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk),
        .spi_sdi(spi_sdi), .spi_sdo_o(spi_sdo_o), .spi_sdo_oe(spi_sdo_oe),
        .offhook_control(offhook_control), .onhook_speed_sel_a(onhook_speed_sel_a),
        .onhook_speed_sel_b(onhook_speed_sel_b), .guard_companion_bit(guard_companion_bit),
        .hybrid_tap_eight_coeff(hybrid_tap_eight_coeff),
        .hybrid_tap_eight_active(hybrid_tap_eight_active),
        .quench_sel_high(quench_sel_high), .quench_sel_low(quench_sel_low),
        .rx_gain_step(rx_gain_step), .guarded_clear_enable(guarded_clear_enable),
        .loop_current_on(loop_current_on), .guarded_clear_draw(guarded_clear_draw)
    );

    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic summarize;
        $display("comparisons %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : summarize

    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask : tick

    // Eight mclk per sclk half, well above the synchroniser's need
    task automatic frame(input logic [7:0] cmd, input logic [7:0] adr, input logic [7:0] dat);
        logic [23:0] word;
        word = {cmd, adr, dat};
        spi_cs_n <= 1'b0;
        tick(6);
        check({7'h00, spi_sdo_oe}, 8'h01);
        for (int i = 0; i < 24; i++) begin
            spi_sclk <= 1'b0;
            spi_sdi <= word[23 - i];
            tick(8);
            if (i >= 16) begin
                rd[23 - i] = spi_sdo_o;
            end
            spi_sclk <= 1'b1;
            tick(8);
        end
        spi_sclk <= 1'b0;
        tick(8);
        spi_cs_n <= 1'b1;
        tick(8);
    endtask : frame

    task automatic rd_check(input logic [7:0] adr, input logic [7:0] exp);
        frame(8'h20, adr, 8'h00);
        check(rd, exp);
    endtask : rd_check

    task automatic t_reset;
        check(hybrid_tap_eight_coeff, 8'h00);
        check({7'h00, hybrid_tap_eight_active}, 8'h00);
        check({quench_sel_high, quench_sel_low, rx_gain_step, guarded_clear_enable}, 8'h00);
        check({6'h00, spi_sdo_oe, loop_current_on}, 8'h00);
        $display("test reset done");
    endtask : t_reset

    task automatic t_coeff;
        frame(8'h00, hthc_pkg::ADDR_HYBRID_TAP_EIGHT_COEFF, 8'hA5);
        check(hybrid_tap_eight_coeff, 8'hA5);
        check({7'h00, hybrid_tap_eight_active}, 8'h01);
        rd_check(hthc_pkg::ADDR_HYBRID_TAP_EIGHT_COEFF, 8'hA5);
        frame(8'h00, hthc_pkg::ADDR_HYBRID_TAP_EIGHT_COEFF, 8'h00);
        check({7'h00, hybrid_tap_eight_active}, 8'h00);
        rd_check(hthc_pkg::ADDR_HYBRID_TAP_EIGHT_COEFF, 8'h00);
        $display("test coefficient done");
    endtask : t_coeff

    task automatic t_ctrl;
        frame(8'h00, hthc_pkg::ADDR_CTRL, 8'h56);
        check({quench_sel_high, quench_sel_low, rx_gain_step, guarded_clear_enable}, 8'h0F);
        rd_check(hthc_pkg::ADDR_CTRL, 8'h56);
        frame(8'h00, hthc_pkg::ADDR_CTRL, 8'h04);
        check({7'h00, rx_gain_step}, 8'h01);
        check({7'h00, guarded_clear_enable}, 8'h00);
        rd_check(hthc_pkg::ADDR_CTRL, 8'h04);
        // Host never writes the reserved range; an unmapped write must not disturb neighbours
        frame(8'h00, 8'h3C, 8'h77);
        rd_check(hthc_pkg::ADDR_RSVD_FIRST, 8'h00);
        rd_check(hthc_pkg::ADDR_RSVD_LAST, 8'h00);
        rd_check(hthc_pkg::ADDR_CTRL, 8'h04);
        $display("test control done");
    endtask : t_ctrl

    task automatic hook_time(input logic a, input logic b, input logic [7:0] c, output int n);
        frame(8'h00, hthc_pkg::ADDR_CTRL, c);
        onhook_speed_sel_a <= a;
        onhook_speed_sel_b <= b;
        offhook_control <= 1'b1;
        tick(4);
        check({7'h00, loop_current_on}, 8'h01);
        offhook_control <= 1'b0;
        n = 0;
        // Judge on the falling edge so the level is settled
        @(negedge mclk);
        while (loop_current_on === 1'b1 && n < 200) begin
            @(negedge mclk);
            n++;
        end
        if (n == 200) begin
            n_errors++;
        end
        tick(1);
    endtask : hook_time

    task automatic t_hook;
        hook_time(1'b0, 1'b0, 8'h00, t_fast);
        hook_time(1'b0, 1'b1, 8'h00, t_mid);
        hook_time(1'b1, 1'b0, 8'h50, t_slow);
        // Offsets in the count cancel in the spacing; the fast count is also judged on its own
        check(8'(t_mid - t_fast), 8'h05);
        check(8'(t_slow - t_mid), 8'h0A);
        check(8'(t_fast), 8'h06);
        frame(8'h00, hthc_pkg::ADDR_CTRL, 8'h02);
        guard_companion_bit <= 1'b1;
        tick(4);
        check({7'h00, guarded_clear_draw}, 8'h01);
        offhook_control <= 1'b1;
        tick(4);
        check({7'h00, guarded_clear_draw}, 8'h00);
        offhook_control <= 1'b0;
        guard_companion_bit <= 1'b0;
        tick(40);
        check({7'h00, guarded_clear_draw}, 8'h00);
        $display("test hook done");
    endtask : t_hook

    initial begin
        nrst = 1'b0;
        spi_cs_n = 1'b1;
        spi_sclk = 1'b0;
        spi_sdi = 1'b0;
        offhook_control = 1'b0;
        onhook_speed_sel_a = 1'b0;
        onhook_speed_sel_b = 1'b0;
        guard_companion_bit = 1'b0;
        tick(2);
        nrst <= 1'b1;
        tick(6);
        t_reset();
        t_coeff();
        t_ctrl();
        t_hook();
        summarize();
    end

    // About 16 frames of some 406 cycles each plus hook waits
    initial begin
        tick(40000);
        n_errors++;
        summarize();
    end
endmodule : hthc_regs_tb
